// [orcs_regs.svh]
// register offsets, field positions, reset values and timing counts of the release and code supervisor
`ifndef ORCS_REGS_SVH
`define ORCS_REGS_SVH
// register byte offsets
`define ORCS_CTRL_OFF 12'h000
`define ORCS_SPEED_OFF 12'h004
`define ORCS_BUTTON_OFF 12'h008
`define ORCS_CODEIN_OFF 12'h00C
`define ORCS_STATUS_OFF 12'h010
`define ORCS_DISPLAY_OFF 12'h014
// ctrl fields
`define ORCS_CTRL_MODE_LSB 0
`define ORCS_CTRL_CAB_BIT 3
`define ORCS_CTRL_SBCFG_BIT 4
`define ORCS_CTRL_TRACTION_BIT 5
`define ORCS_CTRL_RESET 32'h0000_0010
// speed fields: current [7:0], permitted [15:8], first intervention [23:16], second [31:24]
`define ORCS_SPEED_RESET 32'h0000_0000
`define ORCS_STANDSTILL_KMH 8'h02
// button write bits, self clearing
`define ORCS_BTN_REQ_BIT 0
`define ORCS_BTN_ACK_BIT 1
`define ORCS_BTN_MSG_BIT 2
// millisecond tick: 1 ms tick at 250 MHz, timers count ms
`define ORCS_CLK_MHZ 250
`define ORCS_TICK_NS 1000000
`define ORCS_TICK_CYCLES (`ORCS_TICK_NS * `ORCS_CLK_MHZ / 1000)
`define ORCS_CONFIRM_MS 16'd7000
`define ORCS_NOCODE_WAIT_MS 16'd15000
`define ORCS_STILL_WIN_MS 16'd15000
`define ORCS_ABORT_MS 16'd7000
// minimum detection times in ms, chosen at the table's lower bound
`define ORCS_DET_NONE_MS 16'd4000
`define ORCS_DET_50_MS 16'd4000
`define ORCS_DET_75_MS 16'd2500
`define ORCS_DET_180_MS 16'd2000
`endif

// [orcs_pkg.sv]
// types of the release and code supervisor
package orcs_pkg;
  typedef enum logic [2:0] {
    ORCS_CODE_NONE, ORCS_CODE_50, ORCS_CODE_75, ORCS_CODE_120,
    ORCS_CODE_180, ORCS_CODE_270, ORCS_CODE_420
  } orcs_code_t;
  typedef enum logic [2:0] {
    ORCS_MODE_OTHER, ORCS_MODE_FULL, ORCS_MODE_DEG_FULL, ORCS_MODE_WARN, ORCS_MODE_DEG_WARN
  } orcs_mode_t;
  typedef enum logic [1:0] {ORCS_CLS_BELOW, ORCS_CLS_WARN, ORCS_CLS_INTERV} orcs_class_t;
  typedef enum logic [2:0] {
    ORCS_RR_IDLE, ORCS_RR_ACK, ORCS_RR_MSG, ORCS_RR_WAIT, ORCS_RR_ACTIVE
  } orcs_rr_t;
endpackage

// [orcs_supervisor.sv]
// release and code supervisor: brake revocation, tones, speed class, creep release, cab code tracking
//
// Operation
// - service brake checking enabled exactly while service brake is demanded
// - brake demands withdrawn only below permitted speed with no traction request
// - after release the operating mode is kept unchanged
// - speed classified three ways against permitted and first intervention speed
// - warning tone while speed exceeds permitted speed
// - service brake tone while service brake demanded
// - emergency brake tone while emergency brake demanded
// - release request accepted only in protection or warning-system modes
// - request shows confirm button with flashing border, starts seven-second timer
// - confirm not pressed in time: request abandoned, button removed
// - confirm pressed: button removed, second message shown by mode and standstill
// - message not pressed in seven seconds: request abandoned, message removed
// - message pressed in time: message removed
// - wait fifteen seconds for no-code, then activate with icon and tone, else cancel
// - pending request cancelled on change to 75, 180, 420 or 270 code
// - active release ends on valid code, standstill, or fifteen-second standstill cases
// - code taken only from the active cab's coils
// - normal and reserve receiver swapped at every power-on; not done here, swap stays 0 so receiver 0 is always normal
// - current code always one of seven code values
// - invalid, unmodulated or missing carrier maps to no-code
// - transition begins when decoded code differs from current code
// - transition completes after the minimum detection time of the new code
// - current code held during transition, new code adopted at completion
// - repeated changes not completed within seven seconds abort to no-code
// - standstill when speed is below two kilometres per hour
`timescale 1ns/1ps
`default_nettype none
`include "orcs_regs.svh"
module orcs_supervisor
  import orcs_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pickup coil receivers, code and valid per cab and receiver
  input wire logic [2:0] cab0_rx0_code,
  input wire logic cab0_rx0_valid,
  input wire logic [2:0] cab0_rx1_code,
  input wire logic cab0_rx1_valid,
  input wire logic [2:0] cab1_rx0_code,
  input wire logic cab1_rx0_valid,
  input wire logic [2:0] cab1_rx1_code,
  input wire logic cab1_rx1_valid,
  // brake demands from the speed supervisor logic
  output logic emergency_brake,
  output logic service_brake,
  output logic traction_cutoff,
  output logic sb_check_enable,
  // driver display tones and indications
  output logic warning_tone,
  output logic service_tone,
  output logic emergency_tone,
  output logic release_tone,
  output logic [1:0] speed_class,
  output logic confirm_button_shown,
  output logic [1:0] message_shown,
  output logic release_active,
  output logic [2:0] current_code,
  output logic normal_receiver
);
  // ==========================================================
  // registers and bus
  logic [31:0] ctrl, next_ctrl, speed, next_speed;
  logic [2:0] btn, next_btn;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr;
  logic [7:0] v_cur, v_perm, v_fi, v_si;
  orcs_mode_t mode;
  logic cab_sel, sb_cfg, traction_req, standstill;
  assign wr = psel && penable && pwrite && !pready;
  assign v_cur = speed[7:0];
  assign v_perm = speed[15:8];
  assign v_fi = speed[23:16];
  assign v_si = speed[31:24];
  assign mode = orcs_mode_t'(ctrl[`ORCS_CTRL_MODE_LSB +: 3]);
  assign cab_sel = ctrl[`ORCS_CTRL_CAB_BIT];
  assign sb_cfg = ctrl[`ORCS_CTRL_SBCFG_BIT];
  assign traction_req = ctrl[`ORCS_CTRL_TRACTION_BIT];
  assign standstill = v_cur < `ORCS_STANDSTILL_KMH;

  function automatic logic [15:0] min_detect(input orcs_code_t c);
    unique case (c)
      ORCS_CODE_NONE: min_detect = `ORCS_DET_NONE_MS;
      ORCS_CODE_50: min_detect = `ORCS_DET_50_MS;
      ORCS_CODE_75, ORCS_CODE_120: min_detect = `ORCS_DET_75_MS;
      default: min_detect = `ORCS_DET_180_MS;
    endcase
  endfunction

  // ==========================================================
  // millisecond tick
  logic [17:0] tick_cnt, next_tick_cnt;
  logic tick;
  assign tick = tick_cnt == 18'(`ORCS_TICK_CYCLES - 1);
  always_comb begin
    next_tick_cnt = tick ? 18'h0_0000 : tick_cnt + 18'h0_0001;
  end

  // ==========================================================
  // speed supervision and brakes
  logic next_eb, next_sb, next_tco, over_ok;
  always_comb begin
    next_eb = emergency_brake;
    next_sb = service_brake;
    next_tco = traction_cutoff;
    // revoke only below permitted with no traction request
    over_ok = (v_cur < v_perm) && !traction_req;
    if (v_cur >= v_si) begin
      next_eb = 1'b1;
    end else if (v_cur >= v_fi) begin
      if (sb_cfg) begin
        next_sb = 1'b1;
        next_tco = 1'b1;
      end else begin
        next_eb = 1'b1;
      end
    end else if (over_ok) begin
      next_eb = 1'b0;
      next_sb = 1'b0;
      next_tco = 1'b0;
    end
  end

  // ==========================================================
  // cab code tracking
  orcs_code_t cur_code, next_cur_code, pend_code, next_pend_code, dec_code;
  logic in_trans, next_in_trans, multi, next_multi, swap, next_swap;
  logic [15:0] det_ms, next_det_ms, tr_ms, next_tr_ms;
  logic [2:0] raw_code;
  logic raw_valid;
  always_comb begin
    // active cab only; swap stays 0, so receiver 0 is always used
    if (!cab_sel) begin
      raw_code = swap ? cab0_rx1_code : cab0_rx0_code;
      raw_valid = swap ? cab0_rx1_valid : cab0_rx0_valid;
    end else begin
      raw_code = swap ? cab1_rx1_code : cab1_rx0_code;
      raw_valid = swap ? cab1_rx1_valid : cab1_rx0_valid;
    end
    // invalid or out of range decodes as no-code
    dec_code = (raw_valid && raw_code <= 3'(ORCS_CODE_420)) ? orcs_code_t'(raw_code) : ORCS_CODE_NONE;
  end
  always_comb begin
    next_cur_code = cur_code;
    next_pend_code = pend_code;
    next_in_trans = in_trans;
    next_multi = multi;
    next_det_ms = det_ms;
    next_tr_ms = tr_ms;
    next_swap = swap;
    if (!in_trans) begin
      if (dec_code != cur_code) begin
        next_in_trans = 1'b1;
        next_pend_code = dec_code;
        next_multi = 1'b0;
        next_det_ms = 16'h0000;
        next_tr_ms = 16'h0000;
      end
    end else begin
      if (dec_code != pend_code) begin
        next_pend_code = dec_code;
        next_det_ms = 16'h0000;
        next_multi = 1'b1;
      end else if (tick) begin
        next_det_ms = det_ms + 16'h0001;
      end
      if (tick) begin
        next_tr_ms = tr_ms + 16'h0001;
      end
      // adopt after the minimum detection time
      if (dec_code == pend_code && det_ms >= min_detect(pend_code)) begin
        next_cur_code = pend_code;
        next_in_trans = 1'b0;
      // repeated changes beyond seven seconds abort to no-code
      end else if (multi && tr_ms >= `ORCS_ABORT_MS) begin
        next_cur_code = ORCS_CODE_NONE;
        next_in_trans = 1'b0;
      end else if (dec_code == cur_code && dec_code != pend_code) begin
        next_in_trans = 1'b0;
      end
    end
  end

  // ==========================================================
  // creep release sequence
  orcs_rr_t rr, next_rr;
  logic [15:0] rr_ms, next_rr_ms, still_ms, next_still_ms;
  logic moving_act, next_moving_act, lost, next_lost;
  logic next_confirm, next_rel_tone;
  logic [1:0] next_msg;
  logic mode_ok, bad_code;
  always_comb begin
    // accepted in the two protection and two warning-system modes
    mode_ok = mode inside {ORCS_MODE_FULL, ORCS_MODE_DEG_FULL, ORCS_MODE_WARN, ORCS_MODE_DEG_WARN};
    bad_code = (next_cur_code != cur_code) &&
      (next_cur_code inside {ORCS_CODE_75, ORCS_CODE_180, ORCS_CODE_420, ORCS_CODE_270});
    next_rr = rr;
    next_rr_ms = tick ? rr_ms + 16'h0001 : rr_ms;
    next_still_ms = still_ms;
    next_moving_act = moving_act;
    next_lost = lost;
    next_confirm = 1'b0;
    next_msg = 2'b00;
    next_rel_tone = 1'b0;
    unique case (rr)
      ORCS_RR_IDLE: begin
        next_rr_ms = 16'h0000;
        if (btn[`ORCS_BTN_REQ_BIT] && mode_ok) begin
          next_rr = ORCS_RR_ACK;
        end
      end
      ORCS_RR_ACK: begin
        if (btn[`ORCS_BTN_ACK_BIT]) begin
          next_rr = ORCS_RR_MSG;
          next_rr_ms = 16'h0000;
        end else if (rr_ms >= `ORCS_CONFIRM_MS) begin
          next_rr = ORCS_RR_IDLE;
        end
      end
      ORCS_RR_MSG: begin
        if (btn[`ORCS_BTN_MSG_BIT]) begin
          next_rr = ORCS_RR_WAIT;
          next_rr_ms = 16'h0000;
          next_moving_act = !standstill;
        end else if (rr_ms >= `ORCS_CONFIRM_MS) begin
          next_rr = ORCS_RR_IDLE;
        end
      end
      ORCS_RR_WAIT: begin
        if (cur_code == ORCS_CODE_NONE && !in_trans) begin
          next_rr = ORCS_RR_ACTIVE;
          next_moving_act = !standstill;
          next_lost = 1'b0;
          next_still_ms = 16'h0000;
        end else if (rr_ms >= `ORCS_NOCODE_WAIT_MS) begin
          next_rr = ORCS_RR_IDLE;
        end
      end
      ORCS_RR_ACTIVE: begin
        next_rel_tone = 1'b1;
        if (tick && still_ms < `ORCS_STILL_WIN_MS) begin
          next_still_ms = still_ms + 16'h0001;
        end
        if (!standstill && still_ms < `ORCS_STILL_WIN_MS) begin
          next_lost = 1'b1;
        end
        if (cur_code != ORCS_CODE_NONE ||
            (moving_act && standstill) ||
            (!moving_act && lost && standstill) ||
            (!moving_act && !lost && still_ms >= `ORCS_STILL_WIN_MS)) begin
          next_rr = ORCS_RR_IDLE;
          next_rel_tone = 1'b0;
        end
      end
    endcase
    // cancel pending request on listed code change
    if (bad_code && rr inside {ORCS_RR_ACK, ORCS_RR_MSG, ORCS_RR_WAIT}) begin
      next_rr = ORCS_RR_IDLE;
    end
    if (next_rr == ORCS_RR_ACK) begin
      next_confirm = 1'b1;
    end
    next_rel_tone = next_rr == ORCS_RR_ACTIVE;
    if (next_rr == ORCS_RR_MSG) begin
      // 01 moving message in protection modes, 10 standstill message
      next_msg = standstill ? 2'b10 :
        ((mode inside {ORCS_MODE_FULL, ORCS_MODE_DEG_FULL}) ? 2'b01 : 2'b00);
    end
  end

  // ==========================================================
  // bus decode
  always_comb begin
    next_ctrl = ctrl;
    next_speed = speed;
    next_btn = 3'b000;
    next_prdata = prdata;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        `ORCS_CTRL_OFF: begin
          if (wr) next_ctrl = {26'h000_0000, pwdata[5:0]};
          next_prdata = ctrl;
        end
        `ORCS_SPEED_OFF: begin
          if (wr) next_speed = pwdata;
          next_prdata = speed;
        end
        `ORCS_BUTTON_OFF: begin
          if (wr) next_btn = pwdata[2:0];
        end
        `ORCS_CODEIN_OFF: next_prdata = {28'h000_0000, in_trans, pend_code};
        `ORCS_STATUS_OFF: next_prdata = {16'h0000, 3'(rr), 1'b0, 3'(cur_code), swap,
          2'(speed_class), emergency_brake, service_brake, traction_cutoff, warning_tone, 2'b00};
        `ORCS_DISPLAY_OFF: next_prdata = {26'h000_0000, release_tone, release_active,
          message_shown, confirm_button_shown, sb_check_enable};
        default: next_pslverr = 1'b1;
      endcase
    end
  end
  // the mode field is written only by software, never forced here

  // ==========================================================
  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `ORCS_CTRL_RESET;
      speed <= `ORCS_SPEED_RESET;
      btn <= 3'b000;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tick_cnt <= 18'h0_0000;
      emergency_brake <= 1'b0;
      service_brake <= 1'b0;
      traction_cutoff <= 1'b0;
      sb_check_enable <= 1'b0;
      warning_tone <= 1'b0;
      service_tone <= 1'b0;
      emergency_tone <= 1'b0;
      release_tone <= 1'b0;
      speed_class <= 2'b00;
      confirm_button_shown <= 1'b0;
      message_shown <= 2'b00;
      release_active <= 1'b0;
      current_code <= 3'b000;
      normal_receiver <= 1'b0;
      cur_code <= ORCS_CODE_NONE;
      pend_code <= ORCS_CODE_NONE;
      in_trans <= 1'b0;
      multi <= 1'b0;
      det_ms <= 16'h0000;
      tr_ms <= 16'h0000;
      swap <= 1'b0;
      rr <= ORCS_RR_IDLE;
      rr_ms <= 16'h0000;
      still_ms <= 16'h0000;
      moving_act <= 1'b0;
      lost <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      speed <= next_speed;
      btn <= next_btn;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      tick_cnt <= next_tick_cnt;
      emergency_brake <= next_eb;
      service_brake <= next_sb;
      traction_cutoff <= next_tco;
      // checking follows the service brake demand
      sb_check_enable <= next_sb;
      warning_tone <= v_cur > v_perm;
      service_tone <= next_sb;
      emergency_tone <= next_eb;
      release_tone <= next_rel_tone;
      speed_class <= (v_cur < v_perm) ? 2'(ORCS_CLS_BELOW) :
        (v_cur < v_fi) ? 2'(ORCS_CLS_WARN) : 2'(ORCS_CLS_INTERV);
      confirm_button_shown <= next_confirm;
      message_shown <= next_msg;
      release_active <= next_rr == ORCS_RR_ACTIVE;
      // held code is always one of seven values
      current_code <= next_cur_code;
      normal_receiver <= next_swap;
      cur_code <= next_cur_code;
      pend_code <= next_pend_code;
      in_trans <= next_in_trans;
      multi <= next_multi;
      det_ms <= next_det_ms;
      tr_ms <= next_tr_ms;
      swap <= next_swap;
      rr <= next_rr;
      rr_ms <= (next_rr != rr) ? 16'h0000 : next_rr_ms;
      still_ms <= next_still_ms;
      moving_act <= next_moving_act;
      lost <= next_lost;
    end
  end

  // alternation across power-ons needs a history kept outside this block; swap resets to 0
  // ==========================================================
  // checks
  a_sb_check_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    sb_check_enable == service_brake) else $error("brake check not following demand");
  a_brake_release_cond: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(emergency_brake) |-> $past(v_cur) < $past(v_perm) && !$past(traction_req))
    else $error("emergency brake released without conditions");
  a_tone_service: assert property (@(posedge pclk) disable iff (!presetn)
    service_tone == service_brake) else $error("service tone mismatch");
  a_tone_emergency: assert property (@(posedge pclk) disable iff (!presetn)
    emergency_tone == emergency_brake) else $error("emergency tone mismatch");
  a_warn_tone: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 warning_tone == ($past(v_cur) > $past(v_perm))) else $error("warning tone wrong");
  a_req_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
    rr == ORCS_RR_IDLE && !mode_ok |=> rr == ORCS_RR_IDLE) else $error("request outside modes");
  a_code_range: assert property (@(posedge pclk) disable iff (!presetn)
    current_code <= 3'(ORCS_CODE_420)) else $error("code out of range");
  a_code_hold: assert property (@(posedge pclk) disable iff (!presetn)
    in_trans && next_in_trans |=> $stable(cur_code)) else $error("code changed mid transition");
  a_release_tone: assert property (@(posedge pclk) disable iff (!presetn)
    release_tone == release_active) else $error("release tone not with icon");
endmodule
`default_nettype wire

// [orcs_coil_model.sv]
// pickup coil receivers of both cabs for the release and code supervisor bench
`timescale 1ns/1ps
`default_nettype none
module orcs_coil_model
  import orcs_pkg::*;
(
  // clock of the noise pattern
  input wire logic pclk,
  // code each cab's coils see, and whether its carrier is good
  input wire logic [2:0] code0,
  input wire logic ok0,
  input wire logic [2:0] code1,
  input wire logic ok1,
  // receiver outputs, two receivers a cab
  output logic [2:0] cab0_rx0_code,
  output logic cab0_rx0_valid,
  output logic [2:0] cab0_rx1_code,
  output logic cab0_rx1_valid,
  output logic [2:0] cab1_rx0_code,
  output logic cab1_rx0_valid,
  output logic [2:0] cab1_rx1_code,
  output logic cab1_rx1_valid
);
  logic [2:0] noise = 3'h0;
  always @(posedge pclk) begin
    noise <= noise + 3'h3;
  end
  // dead carrier leaves code lines wandering
  // a lost carrier never holds its last code, so only valid may be trusted
  assign cab0_rx0_code = ok0 ? code0 : noise;
  assign cab0_rx1_code = ok0 ? code0 : ~noise;
  assign cab1_rx0_code = ok1 ? code1 : noise;
  assign cab1_rx1_code = ok1 ? code1 : ~noise;
  assign cab0_rx0_valid = ok0;
  assign cab0_rx1_valid = ok0;
  assign cab1_rx0_valid = ok1;
  assign cab1_rx1_valid = ok1;
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench of the release and code supervisor
`timescale 1ns/1ps
`default_nettype none
`include "orcs_regs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb_top
  import orcs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] c00, c01, c10, c11, code0, code1, current_code;
  logic v00, v01, v10, v11, ok0, ok1;
  logic emergency_brake, service_brake, traction_cutoff, sb_check_enable;
  logic warning_tone, service_tone, emergency_tone, release_tone;
  logic confirm_button_shown, release_active, normal_receiver;
  logic [1:0] speed_class, message_shown;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;

  orcs_supervisor i_orcs_supervisor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cab0_rx0_code(c00), .cab0_rx0_valid(v00), .cab0_rx1_code(c01), .cab0_rx1_valid(v01),
    .cab1_rx0_code(c10), .cab1_rx0_valid(v10), .cab1_rx1_code(c11), .cab1_rx1_valid(v11),
    .emergency_brake(emergency_brake), .service_brake(service_brake),
    .traction_cutoff(traction_cutoff), .sb_check_enable(sb_check_enable),
    .warning_tone(warning_tone), .service_tone(service_tone), .emergency_tone(emergency_tone),
    .release_tone(release_tone), .speed_class(speed_class),
    .confirm_button_shown(confirm_button_shown), .message_shown(message_shown),
    .release_active(release_active), .current_code(current_code),
    .normal_receiver(normal_receiver)
  );
  orcs_coil_model i_orcs_coil_model (
    .pclk(pclk), .code0(code0), .ok0(ok0), .code1(code1), .ok1(ok1),
    .cab0_rx0_code(c00), .cab0_rx0_valid(v00), .cab0_rx1_code(c01), .cab0_rx1_valid(v01),
    .cab1_rx0_code(c10), .cab1_rx0_valid(v10), .cab1_rx1_code(c11), .cab1_rx1_valid(v11)
  );

  // ==========================================
  // clock, timeout and verdict
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // the run needs a few hundred cycles; the ceiling leaves ample margin
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================
  // access tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ends when pready is high; if it never is, only the bench timeout ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // mode, service brake configured, traction requested, cab
  task automatic wctl(input logic [2:0] m, input logic s, input logic t, input logic c);
    apb(1'b1, `ORCS_CTRL_OFF, {26'h0, t, s, c, m});
    repeat (3) @(posedge pclk);
  endtask
  // permitted 40, first intervention 43, second 45
  task automatic spd(input logic [7:0] v);
    apb(1'b1, `ORCS_SPEED_OFF, {8'h2D, 8'h2B, 8'h28, v});
    repeat (3) @(posedge pclk);
  endtask
  task automatic btn(input int b);
    apb(1'b1, `ORCS_BUTTON_OFF, 32'h0000_0001 << b);
    repeat (3) @(posedge pclk);
  endtask

  // ==========================================
  // tests
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    code0 <= 3'h0;
    code1 <= 3'h0;
    ok0 <= 1'b0;
    ok1 <= 1'b0;
    rst();
    `CHK("brakes", 4'h0, {emergency_brake, service_brake, traction_cutoff, sb_check_enable})
    `CHK("tones", 4'h0, {warning_tone, service_tone, emergency_tone, release_tone})
    `CHK("display", 4'h0, {confirm_button_shown, message_shown, release_active})
    `CHK("code", ORCS_CODE_NONE, current_code)
    `CHK("receiver", 1'b0, normal_receiver)
    apb(1'b0, `ORCS_CTRL_OFF, 32'h0000_0000);
    `CHK("ctrl reset", `ORCS_CTRL_RESET, rd)
    apb(1'b0, 12'h018, 32'h0000_0000);
    `CHK("unmapped", 1'b1, er)
    // overspeed past first intervention with traction held
    wctl(3'd1, 1'b1, 1'b1, 1'b0);
    spd(8'h2C);
    `CHK("sb demand", 4'hF, {service_brake, traction_cutoff, sb_check_enable, service_tone})
    `CHK("warn tone", 1'b1, warning_tone)
    `CHK("class interv", ORCS_CLS_INTERV, speed_class)
    spd(8'h28);
    `CHK("warn at permitted", 1'b0, warning_tone)
    `CHK("class warn", ORCS_CLS_WARN, speed_class)
    `CHK("sb held", 1'b1, service_brake)
    spd(8'h14);
    `CHK("class below", ORCS_CLS_BELOW, speed_class)
    `CHK("sb traction", 4'hF, {service_brake, traction_cutoff, sb_check_enable, service_tone})
    wctl(3'd1, 1'b1, 1'b0, 1'b0);
    `CHK("sb released", 4'h0, {service_brake, traction_cutoff, sb_check_enable, service_tone})
    apb(1'b0, `ORCS_CTRL_OFF, 32'h0000_0000);
    `CHK("mode kept", 3'd1, rd[2:0])
    spd(8'h2E);
    `CHK("eb demand", 2'b11, {emergency_brake, emergency_tone})
    spd(8'h14);
    `CHK("eb released", 2'b00, {emergency_brake, emergency_tone})
    // service brake not configured: emergency brake in its place
    wctl(3'd1, 1'b0, 1'b0, 1'b0);
    spd(8'h2C);
    `CHK("eb in place", 2'b10, {emergency_brake, service_brake})
    // release request in every mode at standstill
    for (int m = 0; m < 5; m++) begin
      rst();
      wctl(3'(m), 1'b1, 1'b0, 1'b0);
      spd(8'h00);
      btn(`ORCS_BTN_REQ_BIT);
      `CHK("confirm shown", m != 0, confirm_button_shown)
      if (m != 0) begin
        btn(`ORCS_BTN_ACK_BIT);
        `CHK("confirm gone", 1'b0, confirm_button_shown)
        `CHK("still message", 2'b10, message_shown)
        btn(`ORCS_BTN_MSG_BIT);
        `CHK("message gone", 2'b00, message_shown)
        `CHK("release on", 2'b11, {release_active, release_tone})
      end
    end
    // moving in full protection mode gives the other message
    rst();
    wctl(3'd1, 1'b1, 1'b0, 1'b0);
    spd(8'h0A);
    btn(`ORCS_BTN_REQ_BIT);
    btn(`ORCS_BTN_ACK_BIT);
    `CHK("moving message", 2'b01, message_shown)
    // cab code taken from the active cab only, held while in transition
    rst();
    wctl(3'd1, 1'b1, 1'b0, 1'b0);
    code0 <= 3'd4;
    code1 <= 3'd6;
    ok0 <= 1'b1;
    ok1 <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `ORCS_CODEIN_OFF, 32'h0000_0000);
    `CHK("pending cab0", 4'hC, rd[3:0])
    `CHK("code held", ORCS_CODE_NONE, current_code)
    wctl(3'd1, 1'b1, 1'b0, 1'b1);
    apb(1'b0, `ORCS_CODEIN_OFF, 32'h0000_0000);
    `CHK("pending cab1", 4'hE, rd[3:0])
    ok1 <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, `ORCS_CODEIN_OFF, 32'h0000_0000);
    `CHK("lost carrier", 4'h0, rd[3:0])
    `CHK("code valid", ORCS_CODE_NONE, current_code)
    results();
  end
endmodule
`default_nettype wire
